// ### core/lcd_serial_host_port.sv
/*
  serial host port of a character display controller: four-wire clocked
  serial receiver, two-wire addressed bus slave, instruction decode, text
  ram writes and the power-on fill. assumes straps are static and both
  serial links are asynchronous to CLK; the bus pins are open drain.
*/
`timescale 1ns/1ps
module lcd_serial_host_port (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic PORT_TYPE_STRAP_HI,
  input wire logic PORT_TYPE_STRAP_LO,
  input wire logic ADDR_STRAP_LOW,
  input wire logic ADDR_STRAP_HIGH,
  input wire logic PORT_SELECT_LOW,
  input wire logic SERIAL_IN_PIN,
  input wire logic SERIAL_CLK_PIN,
  input wire logic REGISTER_SELECT_LINE,
  input wire logic BUS_CLK_PIN,
  input wire logic BUS_DATA_IN,
  output logic BUS_DATA_OUT,
  output logic BUS_DATA_OE_N,
  output logic INTERNAL_OP_FLAG,
  output logic [6:0] DATA_POINTER,
  output lcd_port_pkg::settings_s SETTINGS,
  output logic [7:0] CMD_BYTE,
  output logic CMD_STROBE,
  input wire logic [lcd_port_pkg::TEXT_RAM_AW-1:0] SCAN_ADDR,
  output logic [7:0] SCAN_DATA
);
  import lcd_port_pkg::*;

  typedef enum logic [2:0] {
    TW_IDLE, TW_ADDR, TW_ACK, TW_CTRL, TW_DATA, TW_IGNORE
  } tw_state_e;

  // two-stage synchronisers; stage one is read only by stage two
  logic [5:0] sync1_ff, sync2_ff, prev_ff;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync1_ff <= 6'h3F;
      sync2_ff <= 6'h3F;
      prev_ff <= 6'h3F;
    end else begin
      sync1_ff <= {PORT_SELECT_LOW, SERIAL_IN_PIN, SERIAL_CLK_PIN,
                   REGISTER_SELECT_LINE, BUS_CLK_PIN, BUS_DATA_IN};
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  wire cs_n = sync2_ff[5];
  wire serial_in_pin = sync2_ff[4];
  wire sclk = sync2_ff[3];
  wire rsel = sync2_ff[2];
  wire scl = sync2_ff[1];
  wire sda = sync2_ff[0];
  wire sclk_rise = sclk & ~prev_ff[3];
  wire scl_rise = scl & ~prev_ff[1];
  wire scl_fall = ~scl & prev_ff[1];
  wire tw_start = scl & prev_ff[1] & ~sda & prev_ff[0];
  wire tw_stop = scl & prev_ff[1] & sda & ~prev_ff[0];

  // straps are pins too: two flip-flops, then a short settle before capture
  logic [3:0] strap_s1_ff, strap_s2_ff;
  logic [1:0] settle_ff;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      strap_s1_ff <= 4'h0;
      strap_s2_ff <= 4'h0;
      settle_ff <= 2'h0;
    end else begin
      strap_s1_ff <= {PORT_TYPE_STRAP_HI, PORT_TYPE_STRAP_LO, ADDR_STRAP_HIGH, ADDR_STRAP_LOW};
      strap_s2_ff <= strap_s1_ff;
      if (!settle_ff[1]) begin
        settle_ff <= settle_ff + 2'h1;
      end
    end
  end

  // straps are caught once, after the synchroniser has filled
  logic straps_taken_ff;
  port_mode_e mode_ff;
  logic [1:0] addr_lo_ff;
  port_mode_e strap_mode;
  assign strap_mode = strap_s2_ff[3] ? PORT_FOUR_WIRE :
                      strap_s2_ff[2] ? PORT_TWO_WIRE : PORT_PARALLEL;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      straps_taken_ff <= 1'b0;
      mode_ff <= PORT_PARALLEL;
      addr_lo_ff <= 2'h0;
    end else if (!straps_taken_ff && settle_ff[1]) begin
      straps_taken_ff <= 1'b1;
      mode_ff <= strap_mode;
      addr_lo_ff <= strap_s2_ff[1:0];
    end
  end
  wire four_wire = (mode_ff == PORT_FOUR_WIRE);
  wire two_wire = (mode_ff == PORT_TWO_WIRE);

  // four-wire receiver: shift on rising clock while selected
  logic [7:0] fw_shift_ff;
  logic [2:0] fw_cnt_ff;
  wire fw_bit = four_wire & ~cs_n & sclk_rise;
  wire fw_done = fw_bit & (fw_cnt_ff == 3'h7);
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fw_shift_ff <= 8'h00;
      fw_cnt_ff <= 3'h0;
    end else if (cs_n) begin
      fw_cnt_ff <= 3'h0;
    end else if (fw_bit) begin
      fw_shift_ff <= {fw_shift_ff[6:0], serial_in_pin};
      fw_cnt_ff <= fw_cnt_ff + 3'h1;
    end
  end

  // two-wire slave
  tw_state_e tw_ff, nxt_tw;
  tw_state_e after_ack_ff, nxt_after_ack;
  logic [7:0] tw_shift_ff;
  logic [3:0] tw_cnt_ff;
  logic dc_ff, chain_ff, ack_drive_ff;
  logic nxt_dc, nxt_chain;
  wire [7:0] tw_byte = {tw_shift_ff[6:0], sda};
  wire tw_bit = two_wire & scl_rise & (tw_cnt_ff <= LAST_BIT_IDX);
  wire tw_last = tw_bit & (tw_cnt_ff == LAST_BIT_IDX);
  wire addr_hit = (tw_byte[7:3] == ADDR_UPPER) & (tw_byte[2:1] == addr_lo_ff);
  // write only: a read request is not acknowledged, so nothing is ever sent
  // no transmission to master
  wire addr_ok = addr_hit & ~tw_byte[0];
  logic tw_byte_ok;

  // state decode for the two-wire side
  always_comb begin
    nxt_tw = tw_ff;
    nxt_after_ack = after_ack_ff;
    nxt_dc = dc_ff;
    nxt_chain = chain_ff;
    tw_byte_ok = 1'b0;
    if (!two_wire) begin
      nxt_tw = TW_IDLE;
    end else if (tw_start) begin
      nxt_tw = TW_ADDR;
    end else if (tw_stop) begin
      nxt_tw = TW_IDLE;
    end else begin
      unique case (tw_ff)
        TW_IDLE, TW_IGNORE, TW_ACK: begin
        end
        TW_ADDR: begin
          if (tw_last) begin
            nxt_tw = addr_ok ? TW_ACK : TW_IGNORE;
            nxt_after_ack = TW_CTRL;
            nxt_chain = 1'b1;
          end
        end
        TW_CTRL: begin
          if (tw_last) begin
            nxt_tw = TW_ACK;
            nxt_chain = tw_byte[CHAIN_BIT];
            nxt_dc = tw_byte[DC_BIT];
            nxt_after_ack = TW_DATA;
          end
        end
        TW_DATA: begin
          if (tw_last) begin
            nxt_tw = TW_ACK;
            tw_byte_ok = 1'b1;
            nxt_after_ack = chain_ff ? TW_CTRL : TW_DATA;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tw_ff <= TW_IDLE;
      after_ack_ff <= TW_CTRL;
      dc_ff <= 1'b0;
      chain_ff <= 1'b1;
    end else begin
      tw_ff <= (tw_ff == TW_ACK && scl_fall && ack_drive_ff) ? after_ack_ff : nxt_tw;
      after_ack_ff <= nxt_after_ack;
      dc_ff <= nxt_dc;
      chain_ff <= nxt_chain;
    end
  end

  // bit shifter and counter; only the counter is cleared, on start and after each acknowledge
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tw_shift_ff <= 8'h00;
      tw_cnt_ff <= 4'h0;
    end else if (tw_start || (tw_ff == TW_ACK && scl_fall && ack_drive_ff)) begin
      tw_cnt_ff <= 4'h0;
    end else if (tw_bit) begin
      tw_shift_ff <= tw_byte;
      tw_cnt_ff <= tw_cnt_ff + 4'h1;
    end
  end

  // acknowledge driver: pull low from the fall after bit 8 to the next fall
  // hold data low through ack high
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ack_drive_ff <= 1'b0;
    end else if (tw_start || tw_stop || !two_wire) begin
      ack_drive_ff <= 1'b0;
    end else if (tw_ff == TW_ACK && scl_fall) begin
      ack_drive_ff <= ~ack_drive_ff;
    end
  end
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      BUS_DATA_OUT <= 1'b1;
      BUS_DATA_OE_N <= 1'b1;
    end else begin
      BUS_DATA_OUT <= 1'b0;
      BUS_DATA_OE_N <= ~ack_drive_ff;
    end
  end

  // byte merge from both serial ports
  host_byte_s rx;
  assign rx.valid = fw_done | tw_byte_ok;
  assign rx.is_data = fw_done ? rsel : dc_ff;
  assign rx.value = fw_done ? {fw_shift_ff[6:0], serial_in_pin} : tw_byte;

  // power-on fill and core state
  logic init_ff;
  logic [6:0] ptr_ff, fill_ff;
  settings_s set_ff;
  wire fill_last = init_ff & (fill_ff == TEXT_RAM_LAST);
  wire ram_we = init_ff | (rx.valid & rx.is_data);
  wire [6:0] ram_addr = init_ff ? fill_ff : ptr_ff;
  wire [7:0] ram_wdata = init_ff ? SPACE_CODE : rx.value;
  wire cmd_in = ~init_ff & rx.valid & ~rx.is_data;
  wire [7:0] cv = rx.value;
  wire set_addr = cmd_in & cv[7];
  wire set_func = cmd_in & (cv[7:5] == 3'h1);
  wire set_disp = cmd_in & (cv[7:3] == 5'h01);
  wire set_entry = cmd_in & (cv[7:2] == 6'h01);
  wire clear_home = cmd_in & (cv[7:1] == 7'h00);
  wire [6:0] ptr_step = set_ff.step_up ? 7'h01 : 7'h7F;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      init_ff <= 1'b1;
      fill_ff <= INIT_POINTER;
    end else if (init_ff) begin
      fill_ff <= fill_ff + 7'h01;
      init_ff <= ~fill_last;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ptr_ff <= INIT_POINTER;
    end else if (init_ff || clear_home) begin
      ptr_ff <= INIT_POINTER;
    end else if (set_addr) begin
      ptr_ff <= cv[6:0];
    end else if (ram_we) begin
      ptr_ff <= ptr_ff + ptr_step;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      set_ff <= '{INIT_WIDTH_8, INIT_TWO_LINES, INIT_TALL_FONT, INIT_DISPLAY_ON,
                  INIT_CURSOR_ON, INIT_BLINK_ON, INIT_STEP_UP, INIT_SHIFT_ALL};
    end else if (set_func) begin
      // host keeps width bit at one
      set_ff.width_8 <= cv[4];
      set_ff.two_lines <= cv[3];
      set_ff.tall_font <= cv[2];
    end else if (set_disp) begin
      set_ff.display_on <= cv[2];
      set_ff.cursor_on <= cv[1];
      set_ff.blink_on <= cv[0];
    end else if (set_entry) begin
      set_ff.step_up <= cv[1];
      set_ff.shift_all <= cv[0];
    end
  end

  // flag and pointer only as plain outputs, never shifted back serially
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      INTERNAL_OP_FLAG <= 1'b1;
      DATA_POINTER <= INIT_POINTER;
      SETTINGS <= '0;
      CMD_BYTE <= 8'h00;
      CMD_STROBE <= 1'b0;
    end else begin
      INTERNAL_OP_FLAG <= init_ff;
      DATA_POINTER <= ptr_ff;
      SETTINGS <= set_ff;
      CMD_STROBE <= cmd_in;
      if (cmd_in) begin
        CMD_BYTE <= cv;
      end
    end
  end

  // text store; scan port for the display refresh side
  text_ram u_text_ram (
    .clk(CLK),
    .wr_en(ram_we),
    .wr_addr(ram_addr),
    .wr_data(ram_wdata),
    .rd_addr(SCAN_ADDR),
    .rd_data(SCAN_DATA)
  );
endmodule : lcd_serial_host_port

// ### core/text_ram.sv
/*
  display text ram, one write port and one registered read port.
  assumes writes and reads share the single system clock.
*/
`timescale 1ns/1ps
module text_ram (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [lcd_port_pkg::TEXT_RAM_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [lcd_port_pkg::TEXT_RAM_AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  import lcd_port_pkg::*;
  logic [7:0] mem [TEXT_RAM_DEPTH];

  // no reset on the array; the controller fills it after power-on
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : text_ram

// ### dv/host_model.sv
/*
  host master model for both serial links, 125 ns bit period.
  assumes the bench resolves the open-drain data line with a pull-up.
*/
`timescale 1ns/1ps
module host_model (
  input wire logic sda,
  output logic scl,
  output logic sda_low,
  output logic sclk,
  output logic serial_in_pin,
  output logic cs_n,
  output logic rs
);
  localparam realtime QTR = 31.25;

  // idle: clocks high, data line released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    sclk = 1'b1;
    serial_in_pin = 1'b0;
    cs_n = 1'b1;
    rs = 1'b0;
  end

  task automatic bit_out(input logic b);
    sda_low = !b;
    #QTR scl = 1'b1;
    #(2*QTR) scl = 1'b0;
    #QTR;
  endtask : bit_out

  task automatic byte_out(input logic [7:0] v, inout int acks);
    for (int i = 7; i >= 0; i--) bit_out(v[i]);
    sda_low = 1'b0;
    #QTR scl = 1'b1;
    #QTR if (sda === 1'b0) acks++;
    #QTR scl = 1'b0;
    #QTR;
  endtask : byte_out

  task automatic frame(input logic [7:0] b[$], output int acks);
    acks = 0;
    sda_low = 1'b1;
    #(2*QTR) scl = 1'b0;
    #QTR;
    foreach (b[i]) byte_out(b[i], acks);
    sda_low = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda_low = 1'b0;
    #(4*QTR);
  endtask : frame

  task automatic spi_byte(input logic t, input logic [7:0] v);
    cs_n = 1'b0;
    rs = t;
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b0;
      serial_in_pin = v[i];
      #(2*QTR) sclk = 1'b1;
      #(2*QTR);
    end
    // deselected lines show no stale value
    cs_n = 1'b1;
    serial_in_pin = !serial_in_pin;
    rs = !rs;
    #(4*QTR);
  endtask : spi_byte
endmodule : host_model

// ### dv/lcd_port_chk.sv
/*
  pin-level checks for the serial host port.
  assumes binding to lcd_serial_host_port, single CLK domain.
*/
`timescale 1ns/1ps
module lcd_port_chk (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic BUS_CLK_PIN,
  input wire logic BUS_DATA_OUT,
  input wire logic BUS_DATA_OE_N,
  input wire logic INTERNAL_OP_FLAG,
  input wire lcd_port_pkg::settings_s SETTINGS,
  input wire logic CMD_STROBE
);
  import lcd_port_pkg::*;
  logic [8:0] cnt_ff;
  wire [8:0] nxt_cnt = (cnt_ff == 9'h1FF) ? cnt_ff : cnt_ff + 9'h001;

  // cycles since reset release; saturates so late checks never rearm
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) cnt_ff <= 9'h000;
    else cnt_ff <= nxt_cnt;
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  // power-on fill and default settings
  a_fill_flag_high: assert property (cnt_ff < 9'h078 |-> INTERNAL_OP_FLAG)
    else $error("flag dropped early in fill");
  a_fill_flag_ends: assert property (cnt_ff == 9'h0A0 |-> !INTERNAL_OP_FLAG)
    else $error("fill did not end");
  a_init_width_font: assert property (INTERNAL_OP_FLAG && cnt_ff >= 9'h003 |->
    {SETTINGS.width_8, SETTINGS.two_lines, SETTINGS.tall_font}
    == {INIT_WIDTH_8, INIT_TWO_LINES, INIT_TALL_FONT})
    else $error("bad width or font default");
  a_init_display_off: assert property (INTERNAL_OP_FLAG && cnt_ff >= 9'h003 |->
    !SETTINGS.display_on && !SETTINGS.cursor_on && !SETTINGS.blink_on)
    else $error("display default not off");
  a_init_entry_mode: assert property (INTERNAL_OP_FLAG && cnt_ff >= 9'h003 |->
    SETTINGS.step_up && !SETTINGS.shift_all)
    else $error("bad entry default");
  a_strobe_one_cycle: assert property (CMD_STROBE |-> !INTERNAL_OP_FLAG ##1 !CMD_STROBE)
    else $error("bad instruction strobe");
  // acknowledge drive on the open-drain line
  a_ack_scl_low: assert property ($changed(BUS_DATA_OE_N) |-> !BUS_CLK_PIN)
    else $error("data drive moved with clock high");
  a_ack_pulls_low: assert property (!BUS_DATA_OE_N |-> !BUS_DATA_OUT)
    else $error("ack not driving low");
  a_ack_held: assert property ($fell(BUS_DATA_OE_N) |-> !BUS_DATA_OE_N[*8])
    else $error("ack too short");
  a_ack_released: assert property ($fell(BUS_DATA_OE_N) |-> ##[1:30] $rose(BUS_DATA_OE_N))
    else $error("ack never released");
endmodule : lcd_port_chk

bind lcd_serial_host_port lcd_port_chk chk (.CLK(CLK), .RESET_N(RESET_N),
  .BUS_CLK_PIN(BUS_CLK_PIN), .BUS_DATA_OUT(BUS_DATA_OUT), .BUS_DATA_OE_N(BUS_DATA_OE_N),
  .INTERNAL_OP_FLAG(INTERNAL_OP_FLAG), .SETTINGS(SETTINGS), .CMD_STROBE(CMD_STROBE));

// ### dv/testbench.sv
/*
  self-checking bench for the serial host port, two-wire then four-wire.
  assumes host_model as far side and the bound pin checker.
*/
`timescale 1ns/1ps
module testbench;
  import lcd_port_pkg::*;
  typedef struct {logic [7:0] a, c, d; int acks; logic [6:0] p; logic [7:0] s;} row_s;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic strap_hi = 1'b0;
  logic strap_lo = 1'b1;
  logic [6:0] scan_addr = 7'h00;
  int bad_count = 0;
  int total_checks = 0;
  int acks;
  wire scl, sda_low, sclk, serial_in_pin, cs_n, rs, sda, data_out, data_oe_n, op_flag, strobe;
  wire [6:0] ptr;
  wire [7:0] cmd_byte, scan_data;
  wire settings_s settings;
  // straps 1/0 give address 0111110, byte 7C
  row_s rows[7] = '{'{8'h7C, 8'h40, 8'h41, 3, 7'h01, 8'h82},
    '{8'h78, 8'h40, 8'h55, 0, 7'h01, 8'h82}, '{8'h7E, 8'h40, 8'h55, 0, 7'h01, 8'h82},
    '{8'h7D, 8'h40, 8'h55, 0, 7'h01, 8'h82}, '{8'h7C, 8'h00, 8'h0C, 3, 7'h01, 8'h92},
    '{8'h7C, 8'h00, 8'h85, 3, 7'h05, 8'h92}, '{8'h7C, 8'h40, 8'h5A, 3, 7'h06, 8'h92}};

  always #4 clk = !clk;
  // open-drain line with pull-up
  assign sda = !sda_low && (data_oe_n || data_out);

  host_model host (.sda(sda), .scl(scl), .sda_low(sda_low), .sclk(sclk), .serial_in_pin(serial_in_pin),
    .cs_n(cs_n), .rs(rs));

  // select tied low in two-wire mode
  lcd_serial_host_port dut (.CLK(clk), .RESET_N(reset_n), .PORT_TYPE_STRAP_HI(strap_hi),
    .PORT_TYPE_STRAP_LO(strap_lo), .ADDR_STRAP_LOW(1'b0), .ADDR_STRAP_HIGH(1'b1),
    .PORT_SELECT_LOW(strap_hi ? cs_n : 1'b0), .SERIAL_IN_PIN(serial_in_pin), .SERIAL_CLK_PIN(sclk),
    .REGISTER_SELECT_LINE(rs), .BUS_CLK_PIN(scl), .BUS_DATA_IN(sda),
    .BUS_DATA_OUT(data_out), .BUS_DATA_OE_N(data_oe_n), .INTERNAL_OP_FLAG(op_flag),
    .DATA_POINTER(ptr), .SETTINGS(settings), .CMD_BYTE(cmd_byte), .CMD_STROBE(strobe),
    .SCAN_ADDR(scan_addr), .SCAN_DATA(scan_data));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // scan port read, registered one cycle after the address
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    @(posedge clk) scan_addr <= a;
    repeat (2) @(posedge clk);
    #1 chk(scan_data, exp);
  endtask : rd

  // reset with the chosen port type, then wait out the fill
  // straps chosen while reset is held
  task automatic boot(input logic four, input logic two);
    @(posedge clk) reset_n <= 1'b0;
    strap_hi <= four;
    strap_lo <= two;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 400 && op_flag !== 1'b0; i++) @(posedge clk);
    #1 chk({7'h00, op_flag}, 8'h00);
  endtask : boot

  task automatic wrap_up();
    if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  // main sequence: table rows, then chained frame, then four-wire
  initial begin
    boot(1'b0, 1'b1);
    chk(settings, 8'h82);
    chk({1'b0, ptr}, 8'h00);
    for (int i = 0; i < 128; i++) rd(7'(i), SPACE_CODE);
    foreach (rows[i]) begin
      host.frame('{rows[i].a, rows[i].c, rows[i].d}, acks);
      chk(8'(acks), 8'(rows[i].acks));
      chk({1'b0, ptr}, {1'b0, rows[i].p});
      chk(settings, rows[i].s);
    end
    rd(7'h00, 8'h41);
    rd(7'h01, SPACE_CODE);
    rd(7'h05, 8'h5A);
    host.frame('{8'h7C, 8'h80, 8'h04, 8'h40, 8'h61, 8'h62}, acks);
    chk(8'(acks), 8'h06);
    chk(settings, 8'h90);
    chk({1'b0, ptr}, 8'h04);
    rd(7'h06, 8'h61);
    rd(7'h05, 8'h62);
    boot(1'b1, 1'b0);
    chk(settings, 8'h82);
    // two-wire traffic is ignored in four-wire mode
    host.frame('{8'h7C, 8'h40, 8'h77}, acks);
    chk(8'(acks), 8'h00);
    host.spi_byte(1'b0, 8'h0F);
    chk(cmd_byte, 8'h0F);
    chk(settings, 8'h9E);
    host.spi_byte(1'b1, 8'h33);
    chk({1'b0, ptr}, 8'h01);
    rd(7'h00, 8'h33);
    // function set keeps the width bit at one, then clear/home
    host.spi_byte(1'b0, 8'h38);
    chk(settings, 8'hDE);
    host.spi_byte(1'b0, 8'h01);
    chk({1'b0, ptr}, 8'h00);
    chk(cmd_byte, 8'h01);
    // parallel strap: neither serial port may act
    boot(1'b0, 1'b0);
    host.frame('{8'h7C, 8'h40, 8'h44}, acks);
    chk(8'(acks), 8'h00);
    host.spi_byte(1'b1, 8'h55);
    chk({1'b0, ptr}, 8'h00);
    rd(7'h00, SPACE_CODE);
    wrap_up();
  end

  // hang guard; the run needs well under this span
  initial begin
    #500_000;
    bad_count++;
    wrap_up();
  end
endmodule : testbench

// ### include/lcd_port_pkg.sv
/*
  shared constants and carrier types for the display controller serial host port.
  assumes one 125 MHz clock; both serial links arrive as asynchronous pins.
*/
package lcd_port_pkg;
  // two-wire addresses 0111100..0111111: upper five bits fixed, straps give the rest
  localparam logic [4:0] ADDR_UPPER = 5'h0F;
  localparam int ADDR_STRAP_W = 2;
  localparam int TEXT_RAM_DEPTH = 128;
  localparam int TEXT_RAM_AW = 7;
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [6:0] TEXT_RAM_LAST = 7'h7F;
  // settings after power-on initialisation
  localparam logic INIT_WIDTH_8 = 1'b1;
  localparam logic INIT_TWO_LINES = 1'b0;
  localparam logic INIT_TALL_FONT = 1'b0;
  localparam logic INIT_DISPLAY_ON = 1'b0;
  localparam logic INIT_CURSOR_ON = 1'b0;
  localparam logic INIT_BLINK_ON = 1'b0;
  localparam logic INIT_STEP_UP = 1'b1;
  localparam logic INIT_SHIFT_ALL = 1'b0;
  localparam logic [6:0] INIT_POINTER = 7'h00;
  // bit positions inside a two-wire control byte
  localparam int CHAIN_BIT = 7;
  localparam int DC_BIT = 6;
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] LAST_BIT_IDX = 4'h7;

  typedef enum logic [1:0] {PORT_PARALLEL, PORT_TWO_WIRE, PORT_FOUR_WIRE} port_mode_e;

  // one received byte headed for the controller core
  typedef struct packed {
    logic valid;
    logic is_data;
    logic [7:0] value;
  } host_byte_s;

  // controller settings held by the instruction decoder
  typedef struct packed {
    logic width_8;
    logic two_lines;
    logic tall_font;
    logic display_on;
    logic cursor_on;
    logic blink_on;
    logic step_up;
    logic shift_all;
  } settings_s;
endpackage : lcd_port_pkg
